/* File: src/inertial_output_pkg.sv */
/*
 * Package for the inertial output register bank: register byte addresses,
 * word widths, scale constants and the read access enumeration.
 * Assumes the SPI front end delivers word-aligned byte addresses.
 */
package inertial_output_pkg;

    localparam int WORD_W = 16;
    localparam int SAMPLE_W = 32;
    localparam int ADDR_W = 7;
    localparam int AXIS_N = 6;

    // Register byte addresses (low byte of each word)
    localparam logic [ADDR_W-1:0] ADDR_RATE_X_HIGH_WORD    = 7'h06;
    localparam logic [ADDR_W-1:0] ADDR_RATE_Y_EXTRA_BITS   = 7'h08;
    localparam logic [ADDR_W-1:0] ADDR_RATE_Y_HIGH_WORD    = 7'h0A;
    localparam logic [ADDR_W-1:0] ADDR_RATE_Z_EXTRA_BITS   = 7'h0C;
    localparam logic [ADDR_W-1:0] ADDR_RATE_Z_HIGH_WORD    = 7'h0E;
    localparam logic [ADDR_W-1:0] ADDR_LINEAR_X_EXTRA_BITS = 7'h10;
    localparam logic [ADDR_W-1:0] ADDR_LINEAR_X_HIGH_WORD  = 7'h12;
    localparam logic [ADDR_W-1:0] ADDR_LINEAR_Y_EXTRA_BITS = 7'h14;
    localparam logic [ADDR_W-1:0] ADDR_LINEAR_Y_HIGH_WORD  = 7'h16;

    // Axis slots in the sample vector
    localparam int AX_RATE_X = 0;
    localparam int AX_RATE_Y = 1;
    localparam int AX_RATE_Z = 2;
    localparam int AX_LIN_X = 3;
    localparam int AX_LIN_Y = 4;
    localparam int AX_LIN_Z = 5;

    // Reset values and the word read back from unmapped addresses
    localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 32'h0000_0000;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] UNMAPPED_VALUE = 16'h0000;

    // Scale per high-word count, micro units (deg/s and mm/s^2)
    localparam int RATE_SCALE_125_UDPS = 6250;
    localparam int RATE_SCALE_500_UDPS = 25000;
    localparam int RATE_SCALE_2000_UDPS = 100000;
    localparam int LINEAR_SCALE_UMMPS2 = 12250000;

    // Range variant codes
    localparam logic [1:0] RANGE_125 = 2'h0;
    localparam logic [1:0] RANGE_500 = 2'h1;
    localparam logic [1:0] RANGE_2000 = 2'h2;

    typedef enum logic [1:0] {
        WORD_HIGH,
        WORD_EXTRA,
        WORD_NONE
    } word_sel_t;

endpackage

/* File: src/axis_sample_hold.sv */
/*
 * One axis of held sample: both halves load together from one update.
 * Assumes update strobe and sample are synchronous to clk.
 */
`timescale 1ns/100ps
module axis_sample_hold
    import inertial_output_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                clk_en,
    // Sample in
    input  wire logic                update,
    input  wire logic [SAMPLE_W-1:0] sample,
    // Held words
    output logic      [WORD_W-1:0]   high_word,
    output logic      [WORD_W-1:0]   extra_bits
);

    logic [SAMPLE_W-1:0] held;
    logic [SAMPLE_W-1:0] next_held;

    always_comb begin
        next_held = held;
        if (update) begin
            next_held = sample;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            held <= SAMPLE_RESET;
        end else if (clk_en) begin
            held <= next_held;
        end
    end

    // High word upper half, extra bits lower half
    assign high_word  = held[SAMPLE_W-1:WORD_W];
    assign extra_bits = held[WORD_W-1:0];

endmodule // axis_sample_hold

/* File: src/inertial_output_registers.sv */
/*
 * Read-only output register bank for six inertial axes.
 * Assumes the SPI slave issues word reads as a one-cycle read strobe with a
 * byte address, and that the sensing path supplies 32-bit samples scaled
 * per the range variant with a single update strobe for all axes.
 */
`timescale 1ns/100ps
module inertial_output_registers
    import inertial_output_pkg::*;
(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    input  wire logic                       clk_en,
    // Sample path
    input  wire logic                       sample_update,
    input  wire logic [AXIS_N*SAMPLE_W-1:0] samples,
    input  wire logic [1:0]                 rate_range,
    // Register read port
    input  wire logic                       read_strobe,
    input  wire logic [ADDR_W-1:0]          read_addr,
    output logic                            read_valid,
    output logic      [WORD_W-1:0]          read_data,
    output logic                            read_unmapped,
    // Scale report
    output logic      [31:0]                rate_scale_udps
);

    logic [WORD_W-1:0] high_words [AXIS_N];
    logic [WORD_W-1:0] extra_words [AXIS_N];

    // One hold per axis; z linear kept for coherence though not mapped
    for (genvar a = 0; a < AXIS_N; a++) begin : g_axis
        axis_sample_hold u_hold (
            .clk        (clk),
            .reset      (reset),
            .clk_en     (clk_en),
            .update     (sample_update),
            .sample     (samples[a*SAMPLE_W +: SAMPLE_W]),
            .high_word  (high_words[a]),
            .extra_bits (extra_words[a])
        );
    end

    word_sel_t         sel;
    int                axis;
    logic [WORD_W-1:0] next_read_data;
    logic              next_read_valid;
    logic              next_read_unmapped;
    logic [31:0]       next_rate_scale;

    // Address decode; odd byte addresses alias their word
    always_comb begin
        sel  = WORD_NONE;
        axis = AX_RATE_X;
        unique case ({read_addr[ADDR_W-1:1], 1'b0})
            ADDR_RATE_X_HIGH_WORD: begin
                sel  = WORD_HIGH;
                axis = AX_RATE_X;
            end
            ADDR_RATE_Y_EXTRA_BITS: begin
                sel  = WORD_EXTRA;
                axis = AX_RATE_Y;
            end
            ADDR_RATE_Y_HIGH_WORD: begin
                sel  = WORD_HIGH;
                axis = AX_RATE_Y;
            end
            ADDR_RATE_Z_EXTRA_BITS: begin
                sel  = WORD_EXTRA;
                axis = AX_RATE_Z;
            end
            ADDR_RATE_Z_HIGH_WORD: begin
                sel  = WORD_HIGH;
                axis = AX_RATE_Z;
            end
            ADDR_LINEAR_X_EXTRA_BITS: begin
                sel  = WORD_EXTRA;
                axis = AX_LIN_X;
            end
            ADDR_LINEAR_X_HIGH_WORD: begin
                sel  = WORD_HIGH;
                axis = AX_LIN_X;
            end
            ADDR_LINEAR_Y_EXTRA_BITS: begin
                sel  = WORD_EXTRA;
                axis = AX_LIN_Y;
            end
            ADDR_LINEAR_Y_HIGH_WORD: begin
                sel  = WORD_HIGH;
                axis = AX_LIN_Y;
            end
            default: begin
                sel  = WORD_NONE;
                axis = AX_RATE_X;
            end
        endcase
    end

    // Read answer, captured one cycle after the strobe
    always_comb begin
        next_read_valid    = read_strobe;
        next_read_data     = read_data;
        next_read_unmapped = 1'b0;
        if (read_strobe) begin
            unique case (sel)
                WORD_HIGH:  next_read_data = high_words[axis];
                WORD_EXTRA: next_read_data = extra_words[axis];
                WORD_NONE: begin
                    next_read_data     = UNMAPPED_VALUE;
                    next_read_unmapped = 1'b1;
                end
            endcase
        end
    end

    // Scale per rate count follows the range variant strap
    always_comb begin
        unique case (rate_range)
            RANGE_125:  next_rate_scale = 32'(RATE_SCALE_125_UDPS);
            RANGE_500:  next_rate_scale = 32'(RATE_SCALE_500_UDPS);
            RANGE_2000: next_rate_scale = 32'(RATE_SCALE_2000_UDPS);
            default:    next_rate_scale = 32'(RATE_SCALE_2000_UDPS);
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            read_valid      <= 1'b0;
            read_data       <= WORD_RESET;
            read_unmapped   <= 1'b0;
            rate_scale_udps <= 32'h0000_0000;
        end else if (clk_en) begin
            read_valid      <= next_read_valid;
            read_data       <= next_read_data;
            read_unmapped   <= next_read_unmapped;
            rate_scale_udps <= next_rate_scale;
        end
    end

endmodule // inertial_output_registers

/* File: bench/inertial_output_monitor.sv */
/* Checker for the bank read port and scale report.
   Assumes it is bound onto the bank top. */
`timescale 1ns/100ps
module inertial_output_monitor
    import inertial_output_pkg::*;
(
    // Watched ports
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              clk_en,
    input wire logic [1:0]        rate_range,
    input wire logic              read_strobe,
    input wire logic [ADDR_W-1:0] read_addr,
    input wire logic              read_valid,
    input wire logic [WORD_W-1:0] read_data,
    input wire logic              read_unmapped,
    input wire logic [31:0]       rate_scale_udps
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire taken = clk_en && read_strobe;
    a_read_latency: assert property (taken |=> read_valid)
        else $error("read answer missing");
    a_valid_cause: assert property (read_valid && $past(clk_en)
        |-> $past(taken)) else $error("answer without read");
    a_hole_empty: assert property (taken && read_addr[6:1] == 6'h02
        |=> read_unmapped && read_data == 16'h0000)
        else $error("hole not refused");
    a_mapped_flag: assert property (taken && read_addr == 7'h16
        |=> !read_unmapped) else $error("mapped word flagged");
    a_data_hold: assert property (!read_valid |-> $stable(read_data))
        else $error("read data moved");
    a_scale_125: assert property (clk_en && rate_range == 2'h0
        |=> rate_scale_udps == 32'd6250) else $error("scale 125");
    a_scale_500: assert property (clk_en && rate_range == 2'h1
        |=> rate_scale_udps == 32'd25000) else $error("scale 500");
    a_scale_2000: assert property (clk_en && rate_range[1]
        |=> rate_scale_udps == 32'd100000) else $error("scale 2k");
    c_read: cover property (taken ##1 read_valid);
    c_hole: cover property (read_unmapped);
    c_range: cover property (rate_range == 2'h2);
endmodule // inertial_output_monitor
bind inertial_output_registers inertial_output_monitor u_monitor (.clk,
    .reset, .clk_en, .rate_range, .read_strobe, .read_addr, .read_valid,
    .read_data, .read_unmapped, .rate_scale_udps);

/* File: bench/host_reader.sv */
/* Host model issuing one-word reads.
   Assumes a read is taken on rising clk with clk_en high. */
`timescale 1ns/100ps
module host_reader
    import inertial_output_pkg::*;
(
    // Bank read port
    input  wire logic              clk,
    input  wire logic              read_valid,
    input  wire logic [WORD_W-1:0] read_data,
    input  wire logic              read_unmapped,
    output logic                   read_strobe,
    output logic      [ADDR_W-1:0] read_addr
);
    initial begin
        read_strobe = 1'b0;
        read_addr = 7'h7F;
    end
    // Idle address inverted so a stale address never looks valid
    task automatic read(input logic [ADDR_W-1:0] a,
                        output logic [WORD_W-1:0] d, output logic u);
        int n;
        n = 0;
        @(posedge clk);
        #1 read_strobe = 1'b1;
        read_addr = a;
        @(posedge clk);
        #1 read_strobe = 1'b0;
        read_addr = ~a;
        while (read_valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1 n++;
        end
        d = read_data;
        u = read_unmapped;
    endtask
endmodule // host_reader

/* File: bench/test_inertial_output_registers.sv */
/* Self-checking bench for the output bank.
   Assumes host_reader and the bound checker are compiled first. */
`timescale 1ns/100ps
module test_inertial_output_registers
    import inertial_output_pkg::*;
;
    localparam logic [191:0] S0 = {32'h5555_AAAA, 32'h8300_ABCD,
        32'h7D00_1234, 32'h0001_8000, 32'hFFFF_FFFE, 32'h4E20_0000};
    localparam logic [191:0] S1 = {S0[191:128], 32'h8001_0002, S0[95:0]};
    // Row: unmapped flag, address, expected word
    logic [23:0] rows [14] = '{24'h06_4E20, 24'h08_FFFE, 24'h0A_FFFF,
        24'h0B_FFFF, 24'h0C_8000, 24'h0E_0001, 24'h10_1234, 24'h12_7D00,
        24'h14_ABCD, 24'h16_8300, 24'h84_0000, 24'h98_0000, 24'h9A_0000,
        24'hFE_0000};
    logic              clk, reset, clk_en, sample_update, u;
    logic              read_strobe, read_valid, read_unmapped;
    logic [191:0]      samples;
    logic [1:0]        rate_range;
    logic [ADDR_W-1:0] read_addr;
    logic [WORD_W-1:0] read_data, d;
    logic [31:0]       rate_scale_udps;
    int                failures = 0, checked = 0, cycles = 0;
    inertial_output_registers u_dut (.clk, .reset, .clk_en, .sample_update,
        .samples, .rate_range, .read_strobe, .read_addr, .read_valid,
        .read_data, .read_unmapped, .rate_scale_udps);
    host_reader u_host (.clk, .read_valid, .read_data, .read_unmapped,
        .read_strobe, .read_addr);
    task automatic check(input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (failures == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Low enable shows an update that must not be taken
    task automatic load(input logic [191:0] s, input logic en);
        @(posedge clk);
        #1 samples = s;
        sample_update = 1'b1;
        clk_en = en;
        @(posedge clk);
        #1 sample_update = 1'b0;
        clk_en = 1'b1;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            report_and_stop;
        end
    end
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        sample_update = 1'b0;
        samples = '0;
        rate_range = 2'h0;
        repeat (4) @(posedge clk);
        #1 reset = 1'b0;
        u_host.read(ADDR_RATE_Y_HIGH_WORD, d, u);
        check(d, WORD_RESET);
        load(S0, 1'b1);
        foreach (rows[i]) begin
            u_host.read(rows[i][22:16], d, u);
            check(d, rows[i][15:0]);
            check(u, rows[i][23]);
        end
        load(S1, 1'b0);
        u_host.read(ADDR_LINEAR_X_HIGH_WORD, d, u);
        check(d, 16'h7D00);
        load(S1, 1'b1);
        u_host.read(ADDR_LINEAR_X_EXTRA_BITS, d, u);
        check(d, 16'h0002);
        u_host.read(ADDR_LINEAR_X_HIGH_WORD, d, u);
        check(d, 16'h8001);
        for (int r = 0; r < 4; r++) begin
            rate_range = 2'(r);
            repeat (2) @(posedge clk);
            #1 check(rate_scale_udps, r == 0 ? RATE_SCALE_125_UDPS :
                r == 1 ? RATE_SCALE_500_UDPS : RATE_SCALE_2000_UDPS);
        end
        reset = 1'b1;
        @(posedge clk);
        #1 check(rate_scale_udps, 32'h0000_0000);
        check(read_valid, 1'b0);
        reset = 1'b0;
        u_host.read(ADDR_RATE_Z_HIGH_WORD, d, u);
        check(d, WORD_RESET);
        report_and_stop;
    end
endmodule // test_inertial_output_registers
